// ---- hw/pced_pkg.sv ----
package pced_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] ADDR_A_RISE = 12'h000;
  localparam logic [11:0] ADDR_A_FALL = 12'h004;
  localparam logic [11:0] ADDR_A_FLAGS = 12'h008;
  localparam logic [11:0] ADDR_B_RISE = 12'h00c;
  localparam logic [11:0] ADDR_B_FALL = 12'h010;
  localparam logic [11:0] ADDR_B_FLAGS = 12'h014;
  localparam logic [11:0] ADDR_CTRL = 12'h018;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h01c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h020;
  // ==========================================================
  // field layouts
  localparam logic [7:0] A_IMPL = 8'h3f;
  localparam logic [7:0] B_IMPL = 8'hf0;
  localparam int CTRL_MASTER_BIT = 0;
  localparam int STAT_SUMMARY_BIT = 0;
  localparam int STAT_WAKE_BIT = 1;
  localparam int STAT_W = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
endpackage

// ---- hw/pced_top.sv ----
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pced_top #(
  parameter int PIN_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PIN_W-1:0] port_a_pin,
  input wire logic [PIN_W-1:0] port_b_pin,
  output logic pin_change_summary_flag,
  output logic pin_change_irq,
  output logic wake_request,
  output logic irq
);

  // ==========================================================
  // parameter check
  if (PIN_W != 8) begin : g_bad_width
    $error("pced_top: PIN_W must be 8");
  end

  // ==========================================================
  // apb decode
  wire logic acc_phase;
  wire logic wr_en;
  wire logic lane0;
  wire logic [7:0] wbyte;
  wire logic hit_a_rise, hit_a_fall, hit_a_flags;
  wire logic hit_b_rise, hit_b_fall, hit_b_flags;
  wire logic hit_ctrl, hit_stat, hit_mask;
  wire logic hit_any;
  assign acc_phase = psel && penable;
  assign wr_en = acc_phase && pwrite;
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign hit_a_rise = paddr == pced_pkg::ADDR_A_RISE;
  assign hit_a_fall = paddr == pced_pkg::ADDR_A_FALL;
  assign hit_a_flags = paddr == pced_pkg::ADDR_A_FLAGS;
  assign hit_b_rise = paddr == pced_pkg::ADDR_B_RISE;
  assign hit_b_fall = paddr == pced_pkg::ADDR_B_FALL;
  assign hit_b_flags = paddr == pced_pkg::ADDR_B_FLAGS;
  assign hit_ctrl = paddr == pced_pkg::ADDR_CTRL;
  assign hit_stat = paddr == pced_pkg::ADDR_IRQ_STAT;
  assign hit_mask = paddr == pced_pkg::ADDR_IRQ_MASK;
  assign hit_any = hit_a_rise | hit_a_fall | hit_a_flags | hit_b_rise |
    hit_b_fall | hit_b_flags | hit_ctrl | hit_stat | hit_mask;

  // ==========================================================
  // registers
  logic [7:0] a_rise, a_fall, a_flags;
  logic [7:0] b_rise, b_fall, b_flags;
  logic master_en;
  logic [pced_pkg::STAT_W-1:0] stat, mask;

  // ==========================================================
  // pin synchronisers and edge detection
  logic [7:0] a_s1, a_s2, a_prev, b_s1, b_s2, b_prev;
  logic [2:0] prime;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_s1 <= 8'h00;
      a_s2 <= 8'h00;
      a_prev <= 8'h00;
      b_s1 <= 8'h00;
      b_s2 <= 8'h00;
      b_prev <= 8'h00;
      prime <= 3'h0;
    end else begin
      prime <= {prime[1:0], 1'b1};
      a_s1 <= port_a_pin;
      a_s2 <= a_s1;
      a_prev <= a_s2;
      b_s1 <= port_b_pin;
      b_s2 <= b_s1;
      b_prev <= b_s2;
    end
  end

  wire logic [7:0] a_hit, b_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_edge
      // either enabled direction sets the flag
      assign a_hit[gi] = pced_pkg::A_IMPL[gi] && prime[2] &&
        ((a_rise[gi] && a_s2[gi] && !a_prev[gi]) ||
         (a_fall[gi] && !a_s2[gi] && a_prev[gi]));
      assign b_hit[gi] = pced_pkg::B_IMPL[gi] && prime[2] &&
        ((b_rise[gi] && b_s2[gi] && !b_prev[gi]) ||
         (b_fall[gi] && !b_s2[gi] && b_prev[gi]));
    end
  endgenerate

  // ==========================================================
  // next values
  wire logic [7:0] a_clr, b_clr;
  wire logic [7:0] next_a_flags, next_b_flags;
  wire logic next_summary;
  wire logic next_pc_irq;
  wire logic [pced_pkg::STAT_W-1:0] stat_set, stat_clr, next_stat;
  assign a_clr = (wr_en && lane0 && hit_a_flags) ? ~wbyte : 8'h00;
  assign b_clr = (wr_en && lane0 && hit_b_flags) ? ~wbyte : 8'h00;
  // hardware set beats the software clear
  assign next_a_flags = ((a_flags & ~a_clr) | a_hit) & pced_pkg::A_IMPL;
  assign next_b_flags = ((b_flags & ~b_clr) | b_hit) & pced_pkg::B_IMPL;
  assign next_summary = |{next_a_flags, next_b_flags};
  // detection runs regardless, request gated
  assign next_pc_irq = master_en && next_summary;
  assign stat_set = {next_pc_irq && !wake_request, |{a_hit, b_hit}};
  assign stat_clr = (wr_en && lane0 && hit_stat) ?
    wbyte[pced_pkg::STAT_W-1:0] : pced_pkg::STAT_RESET;
  assign next_stat = (stat & ~stat_clr) | stat_set;

  // ==========================================================
  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_rise <= pced_pkg::REG_RESET;
      a_fall <= pced_pkg::REG_RESET;
      b_rise <= pced_pkg::REG_RESET;
      b_fall <= pced_pkg::REG_RESET;
      master_en <= 1'b0;
      mask <= pced_pkg::STAT_RESET;
    end else if (wr_en && lane0) begin
      if (hit_a_rise) a_rise <= wbyte & pced_pkg::A_IMPL;
      if (hit_a_fall) a_fall <= wbyte & pced_pkg::A_IMPL;
      if (hit_b_rise) b_rise <= wbyte & pced_pkg::B_IMPL;
      if (hit_b_fall) b_fall <= wbyte & pced_pkg::B_IMPL;
      if (hit_ctrl) master_en <= wbyte[pced_pkg::CTRL_MASTER_BIT];
      if (hit_mask) mask <= wbyte[pced_pkg::STAT_W-1:0];
    end
  end

  // flags update every cycle, sleep or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_flags <= pced_pkg::REG_RESET;
      b_flags <= pced_pkg::REG_RESET;
      pin_change_summary_flag <= 1'b0;
      pin_change_irq <= 1'b0;
      wake_request <= 1'b0;
      stat <= pced_pkg::STAT_RESET;
      irq <= 1'b0;
    end else begin
      a_flags <= next_a_flags;
      b_flags <= next_b_flags;
      pin_change_summary_flag <= next_summary;
      pin_change_irq <= next_pc_irq;
      wake_request <= next_pc_irq;
      stat <= next_stat;
      irq <= |(next_stat & mask);
    end
  end

  // ==========================================================
  // read mux
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (hit_a_rise) rd_byte = a_rise;
    if (hit_a_fall) rd_byte = a_fall;
    if (hit_a_flags) rd_byte = a_flags;
    if (hit_b_rise) rd_byte = b_rise;
    if (hit_b_fall) rd_byte = b_fall;
    if (hit_b_flags) rd_byte = b_flags;
    if (hit_ctrl) rd_byte = {7'h00, master_en};
    if (hit_stat) rd_byte = {6'h00, stat};
    if (hit_mask) rd_byte = {6'h00, mask};
  end

  // registered answer: no wait state, pready is high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} :
        32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (a_flags != 8'h00 && !(wr_en && hit_a_flags)) |=>
      ((a_flags & $past(a_flags)) == $past(a_flags)))
    else $error("port a flag dropped without write");
  a_rise_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (a_rise[0] && a_s2[0] && !a_prev[0]) |=> a_flags[0])
    else $error("port a rising edge not flagged");
  b_fall_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (b_fall[4] && !b_s2[4] && b_prev[4]) |=> b_flags[4])
    else $error("port b falling edge not flagged");
  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (a_hit[0] && wr_en && hit_a_flags) |=> a_flags[0])
    else $error("edge lost during clear");
  a_summary_or: assert property (@(posedge pclk) disable iff (!presetn)
    pin_change_summary_flag == |{a_flags, b_flags})
    else $error("summary flag mismatch");
  a_master_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!$past(master_en)) |-> !pin_change_irq)
    else $error("request raised with master clear");
  a_wake_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (master_en && |{a_hit, b_hit}) |=> wake_request)
    else $error("no wake after enabled edge");
  a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ((a_rise | a_fall | a_flags) & 8'hc0) == 8'h00 &&
    ((b_rise | b_fall | b_flags) & 8'h0f) == 8'h00)
    else $error("unimplemented bit set");
  a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
    (a_rise[2] && $rose(a_s2[2])) |=> a_flags[2])
    else $error("synchronised edge not flagged");

  // ==========================================================
  // sequences for the checks below
  sequence s_wr_a_rise;
    wr_en && lane0 && hit_a_rise;
  endsequence
  sequence s_wr_a_fall;
    wr_en && lane0 && hit_a_fall;
  endsequence
  sequence s_wr_b_rise;
    wr_en && lane0 && hit_b_rise;
  endsequence
  sequence s_wr_b_fall;
    wr_en && lane0 && hit_b_fall;
  endsequence
  sequence s_clear_a_quiet;
    wr_en && lane0 && hit_a_flags && a_hit == 8'h00;
  endsequence
  sequence s_clear_b_race;
    b_hit != 8'h00 && wr_en && hit_b_flags;
  endsequence

  a_a_rise_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wr_a_rise |=> a_rise == ($past(wbyte) & pced_pkg::A_IMPL))
    else $error("port a rise enable write lost");
  a_a_fall_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wr_a_fall |=> a_fall == ($past(wbyte) & pced_pkg::A_IMPL))
    else $error("port a fall enable write lost");
  a_b_rise_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wr_b_rise |=> b_rise == ($past(wbyte) & pced_pkg::B_IMPL))
    else $error("port b rise enable write lost");
  a_b_fall_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_wr_b_fall |=> b_fall == ($past(wbyte) & pced_pkg::B_IMPL))
    else $error("port b fall enable write lost");
  a_a_hit_flags: assert property (@(posedge pclk)
    disable iff (!presetn)
    a_hit != 8'h00 |=> (a_flags & $past(a_hit)) == $past(a_hit))
    else $error("port a edge not flagged");
  a_b_hit_flags: assert property (@(posedge pclk)
    disable iff (!presetn)
    b_hit != 8'h00 |=> (b_flags & $past(b_hit)) == $past(b_hit))
    else $error("port b edge not flagged");
  a_a_hit_summary: assert property (@(posedge pclk)
    disable iff (!presetn)
    a_hit != 8'h00 |=> pin_change_summary_flag)
    else $error("port a edge missed summary");
  a_b_hit_summary: assert property (@(posedge pclk)
    disable iff (!presetn)
    b_hit != 8'h00 |=> pin_change_summary_flag)
    else $error("port b edge missed summary");
  a_b_set_wins: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_clear_b_race |=> (b_flags & $past(b_hit)) == $past(b_hit))
    else $error("port b edge lost during clear");
  a_a_clear_write: assert property (@(posedge pclk)
    disable iff (!presetn)
    s_clear_a_quiet |=> a_flags == ($past(a_flags) & $past(wbyte)))
    else $error("port a flag clear wrong");
  a_b_flag_sticky: assert property (@(posedge pclk)
    disable iff (!presetn)
    (b_flags != 8'h00 && !(wr_en && hit_b_flags)) |=>
      ((b_flags & $past(b_flags)) == $past(b_flags)))
    else $error("port b flag dropped without write");
  a_both_edges: assert property (@(posedge pclk)
    disable iff (!presetn)
    (a_rise[3] && a_fall[3] && a_s2[3] != a_prev[3] && prime[2]) |=>
      a_flags[3])
    else $error("dual enable edge not flagged");
  a_irq_level: assert property (@(posedge pclk)
    disable iff (!presetn)
    pin_change_irq == ($past(master_en) && pin_change_summary_flag))
    else $error("request does not follow master and summary");
  a_wake_follows: assert property (@(posedge pclk)
    disable iff (!presetn)
    wake_request == pin_change_irq)
    else $error("wake differs from request");
  a_detect_no_master: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!master_en && a_hit != 8'h00) |=> a_flags != 8'h00)
    else $error("detection stopped with master clear");
  a_wake_recorded: assert property (@(posedge pclk)
    disable iff (!presetn)
    $rose(wake_request) |-> pin_change_summary_flag)
    else $error("wake before flag recorded");
  a_no_false_flag: assert property (@(posedge pclk)
    disable iff (!presetn)
    (a_hit == 8'h00 && b_hit == 8'h00) |=>
      ((a_flags & ~$past(a_flags)) == 8'h00 &&
       (b_flags & ~$past(b_flags)) == 8'h00))
    else $error("flag set without edge");
  a_edge_once: assert property (@(posedge pclk)
    disable iff (!presetn)
    (a_s2[0] && !a_prev[0]) |=> a_prev[0])
    else $error("edge seen more than once");
  a_prime_quiet: assert property (@(posedge pclk)
    disable iff (!presetn)
    !prime[2] |-> (a_hit == 8'h00 && b_hit == 8'h00))
    else $error("edge taken before synchroniser settled");
  a_pready_pulse: assert property (@(posedge pclk)
    disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (@(posedge pclk)
    disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

endmodule // pced_top
`default_nettype wire

// ---- bench/pced_pins.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// pin levels, held steady between changes
module pced_pins (
  input wire logic [7:0] want_a,
  input wire logic [7:0] want_b,
  output logic [7:0] port_a_pin,
  output logic [7:0] port_b_pin
);
  assign port_a_pin = want_a;
  assign port_b_pin = want_b;
endmodule // pced_pins
`default_nettype wire

// ---- bench/tb_pin_change_edge_detector.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_pin_change_edge_detector;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, m;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] want_a = 8'h00, want_b = 8'h00, fa, fb, er[4];
  logic err;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, sflag, pirq, wake, irq;
  wire logic [7:0] pa, pb;
  int failures = 0, compares = 0, seed = 84077, n, i;
  localparam logic [11:0] EN[4] = '{pced_pkg::ADDR_A_RISE,
    pced_pkg::ADDR_A_FALL, pced_pkg::ADDR_B_RISE, pced_pkg::ADDR_B_FALL};
  pced_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_pin(pa), .port_b_pin(pb), .pin_change_summary_flag(sflag),
    .pin_change_irq(pirq), .wake_request(wake), .irq(irq));
  pced_pins PINS (.want_a(want_a), .want_b(want_b), .port_a_pin(pa),
    .port_b_pin(pb));
  initial forever #50 pclk = ~pclk;
  // ==========================================
  // shared tasks
  task close_out();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) begin
      failures++;
      close_out();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e, input string s);
    apb(1'b0, a, 8'h00);
    chk(rdat, {24'h000000, e}, s);
  endtask
  function automatic logic [7:0] hit(input logic [7:0] p, c, r, f, im);
    return ((~p & c & r) | (p & ~c & f)) & im;
  endfunction
  task pins(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    fa = fa | hit(want_a, a, er[0], er[1], pced_pkg::A_IMPL);
    fb = fb | hit(want_b, b, er[2], er[3], pced_pkg::B_IMPL);
    want_a <= a;
    want_b <= b;
    repeat (4) @(posedge pclk);
  endtask
  // ==========================================
  // main sequence
  initial begin
    fa = 8'h00;
    fb = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (n = 0; n < 9; n++) rd(12'(4 * n), 8'h00, "reset value");
    $display("test reset done");
    for (n = 0; n < 4; n++) begin
      apb(1'b1, EN[n], 8'hff);
      rd(EN[n], n < 2 ? 8'h3f : 8'hf0, "enable bits");
    end
    pstrb <= 4'he;
    apb(1'b1, EN[0], 8'h00);
    pstrb <= 4'hf;
    rd(EN[0], 8'h3f, "lane0 off write ignored");
    apb(1'b0, 12'h100, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rdat, 32'h0, "unmapped data");
    $display("test registers done");
    for (i = 0; i < 24; i++) begin
      for (n = 0; n < 4; n++) begin
        er[n] = 8'($random(seed));
        apb(1'b1, EN[n], er[n]);
      end
      m = 1'($random(seed));
      apb(1'b1, pced_pkg::ADDR_CTRL, {7'h00, m});
      rd(pced_pkg::ADDR_CTRL, {7'h00, m}, "master enable");
      pins(8'($random(seed)), 8'($random(seed)));
      rd(pced_pkg::ADDR_A_FLAGS, fa, "a flags");
      rd(pced_pkg::ADDR_B_FLAGS, fb, "b flags");
      chk({31'h0, sflag}, {31'h0, |{fa, fb}}, "summary");
      chk({31'h0, pirq}, {31'h0, m & |{fa, fb}}, "irq");
      chk({31'h0, wake}, {31'h0, m & |{fa, fb}}, "wake");
      rd(pced_pkg::ADDR_A_FLAGS, fa, "sticky");
      apb(1'b1, pced_pkg::ADDR_A_FLAGS, rdat[7:0] ^ 8'hff);
      apb(1'b0, pced_pkg::ADDR_B_FLAGS, 8'h00);
      apb(1'b1, pced_pkg::ADDR_B_FLAGS, rdat[7:0] ^ 8'hff);
      fa = 8'h00;
      fb = 8'h00;
      rd(pced_pkg::ADDR_B_FLAGS, 8'h00, "cleared");
    end
    $display("test edges done");
    er[0] = 8'h01;
    er[1] = 8'h00;
    apb(1'b1, EN[0], 8'h01);
    apb(1'b1, EN[1], 8'h00);
    apb(1'b1, pced_pkg::ADDR_CTRL, 8'h01);
    pins(want_a & 8'hfe, want_b);
    @(posedge pclk);
    want_a <= want_a | 8'h01;
    apb(1'b1, pced_pkg::ADDR_A_FLAGS, 8'h00);
    rd(pced_pkg::ADDR_A_FLAGS, 8'h01, "edge wins");
    $display("test clear race done");
    pins(want_a & 8'hfe, want_b);
    apb(1'b1, pced_pkg::ADDR_A_FLAGS, 8'h00);
    apb(1'b1, pced_pkg::ADDR_IRQ_MASK, 8'h00);
    apb(1'b1, pced_pkg::ADDR_IRQ_STAT, 8'h03);
    rd(pced_pkg::ADDR_IRQ_STAT, 8'h00, "status clear");
    pins(want_a | 8'h01, want_b);
    rd(pced_pkg::ADDR_IRQ_STAT, 8'h03, "status set");
    chk({31'h0, irq}, 32'h0, "masked irq");
    apb(1'b1, pced_pkg::ADDR_IRQ_MASK, 8'h01);
    rd(pced_pkg::ADDR_IRQ_MASK, 8'h01, "mask");
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    apb(1'b1, pced_pkg::ADDR_IRQ_STAT, 8'h01);
    rd(pced_pkg::ADDR_IRQ_STAT, 8'h02, "w1c");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test interrupt done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(pced_pkg::ADDR_A_FLAGS, 8'h00, "flags after reset");
    rd(pced_pkg::ADDR_A_RISE, 8'h00, "enable after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test second reset done");
    close_out();
  end
endmodule // tb_pin_change_edge_detector
`default_nettype wire
